// ### hdl/cgc_pkg.sv
// package: register map, field positions, reset values and timing of the clock generator control
package cgc_pkg;
  localparam logic [11:0] CGC_CTRL_ONE_OFS = 12'h000;
  localparam logic [11:0] CGC_CTRL_TWO_OFS = 12'h004;
  localparam logic [11:0] CGC_STATUS_OFS   = 12'h008;

  // control one fields
  localparam int CGC_HGS_BIT   = 7;
  localparam int CGC_FBS_BIT   = 6;
  localparam int CGC_ERS_BIT   = 5;
  localparam int CGC_CMS_LSB   = 3;
  localparam int CGC_OKO_BIT   = 2;
  localparam int CGC_CLDO_BIT  = 1;
  // control two fields
  localparam int CGC_LLRE_BIT  = 7;
  localparam int CGC_MFF_LSB   = 4;
  localparam int CGC_CLRE_BIT  = 3;
  localparam int CGC_ODF_LSB   = 0;
  // status fields
  localparam int CGC_ST_MODE_LSB = 6;
  localparam int CGC_ST_RKIND    = 5;
  localparam int CGC_ST_LLS      = 4;
  localparam int CGC_ST_BUSY     = 3;
  localparam int CGC_ST_CLOSS    = 2;
  localparam int CGC_ST_EROK     = 1;
  localparam int CGC_ST_CLAIM    = 0;

  localparam logic [7:0] CGC_CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CGC_CTRL_TWO_RST = 8'h00;

  // clock 40 MHz; field updates cross into the generator's domain in this time
  localparam int CGC_CLK_PERIOD_PS = 25000;
  localparam int CGC_SYNC_TIME_NS  = 75;
  localparam int CGC_SYNC_CYC      = (CGC_SYNC_TIME_NS * 1000 + CGC_CLK_PERIOD_PS - 1)
                                     / CGC_CLK_PERIOD_PS;
  localparam logic [1:0] CGC_SYNC_LOAD = 2'(CGC_SYNC_CYC);

  localparam logic [7:0] CGC_P_LOW  = 8'h40;
  localparam logic [7:0] CGC_P_HIGH = 8'h01;
  localparam logic [4:0] CGC_N_BASE = 5'h04;

  typedef enum logic [1:0] {
    CGC_SELF_CLOCKED_MODE      = 2'b00,
    CGC_LOOP_ENGAGED_INTERNAL  = 2'b01,
    CGC_LOOP_BYPASSED_EXTERNAL = 2'b10,
    CGC_LOOP_ENGAGED_EXTERNAL  = 2'b11
  } cgc_mode_e;

  // one field that must settle before its new value is applied
  typedef struct packed {
    logic       pend;
    logic [1:0] cnt;
    logic [2:0] req;
    logic [2:0] act;
  } cgc_sfield_s;

  // status inputs from the oscillator and loop datapath
  typedef struct packed {
    logic lock_loss;
    logic clock_loss;
    logic ext_ref_ok;
    logic ref_kind;
  } cgc_stat_s;

  // settings presented to the oscillator, loop and divider
  typedef struct packed {
    logic       high_gain;
    logic       range_high;
    logic       ext_ref_crystal;
    logic       pin_claim;
    logic       osc_enable;
    logic       loss_detect_en;
    cgc_mode_e  mode;
    logic [7:0] prescale_p;
    logic [4:0] mult_n;
    logic [7:0] div_r;
  } cgc_cfg_s;
endpackage

// ### hdl/cgc_sync.sv
// two-stage synchroniser for the asynchronous status inputs
`timescale 1ns/1ps
module cgc_sync
  import cgc_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  if (W < 1) begin : g_bad_w
    $error("cgc_sync: width must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cgc_sy_s;

  cgc_sy_s st_r;
  cgc_sy_s st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

// ### hdl/cgc_ctrl.sv
// clock generator control registers with apb slave
// Function
// - high_gain_select: 0 low power, 1 high gain
// - freq_band_select: 0 sets P=64, 1 sets P=1
// - band setting only counts in external modes
// - ext_ref_select: 0 external clock, 1 crystal
// - write-once bits take only first write
// - mode 00 self-clocked; bypass waits reference ok
// - off mode leaves clock_mode_select unchanged
// - mode, multiplier and divider writes discarded while prior write still synchronising
// - first mode write 0X forbids 1X later
// - oscillator in off mode per osc_keep_in_off
// - osc_keep_in_off ignored when gain and band set
// - clock_loss_detect_off 1 disables loss detection
// - lock loss: interrupt or reset per enable
// - multiplier N equals four plus twice code
// - clock loss: interrupt or reset per enable
// - output divider R equals two to code
// - input pin claimed only by external first write
// - mode codes: self, internal, bypass, external
// - reset starts in self-clocked mode
`timescale 1ns/1ps
module cgc_ctrl
  import cgc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire cgc_stat_s         stat_in,
  input  wire logic              off_mode,
  input  wire logic              osc_off_enable,
  output cgc_cfg_s               cfg,
  output logic                   lock_loss_irq,
  output logic                   lock_loss_rst,
  output logic                   clock_loss_irq,
  output logic                   clock_loss_rst
);
  // the offset decode keeps twelve address bits at most
  if (ADDR_W < 4 || ADDR_W > 12) begin : g_bad_addr_w
    $error("cgc_ctrl: ADDR_W must be 4 to 12");
  end

  typedef struct packed {
    logic        hgs;
    logic        fbs;
    logic        ers;
    logic        oko;
    logic        cldo;
    logic        once_done;
    logic        first_cms;
    logic        ext_lockout;
    logic        pin_claim;
    logic        llre;
    logic        clre;
    cgc_sfield_s cms;
    cgc_sfield_s mff;
    cgc_sfield_s odf;
    logic [31:0] rdata;
  } cgc_st_s;

  cgc_st_s   st_r;
  cgc_st_s   st_nxt;
  cgc_stat_s stat_s;

  cgc_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (stat_in),
    .q       (stat_s)
  );

  function automatic logic [11:0] word_ofs(input logic [ADDR_W-1:0] a);
    logic [11:0] w;
    w = 12'(a);
    return {w[11:2], 2'b00};
  endfunction

  // countdown and apply step shared by the three synchronised fields
  function automatic cgc_sfield_s sfield_step(input cgc_sfield_s f, input logic ok);
    cgc_sfield_s g;
    g = f;
    if (f.pend && f.cnt != 2'h0) begin
      g.cnt = f.cnt - 2'h1;
    end else if (f.pend && ok) begin
      g.act  = f.req;
      g.pend = 1'b0;
    end
    return g;
  endfunction

  // a new value is refused while the previous one is still settling
  function automatic cgc_sfield_s sfield_write(input cgc_sfield_s f, input logic [2:0] v);
    cgc_sfield_s g;
    g = f;
    if (!f.pend) begin
      g.req  = v;
      g.pend = 1'b1;
      g.cnt  = CGC_SYNC_LOAD;
    end
    return g;
  endfunction

  logic        setup;
  logic        wr;
  logic [11:0] ofs;
  logic        mapped;
  logic [1:0]  cms_w;
  logic        bypass_wait;

  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign ofs    = word_ofs(paddr);
  assign mapped = (ofs == CGC_CTRL_ONE_OFS) || (ofs == CGC_CTRL_TWO_OFS) ||
                  (ofs == CGC_STATUS_OFS);
  assign cms_w  = pwdata[CGC_CMS_LSB +: 2];
  // bypass mode is held back until the external reference is good
  assign bypass_wait = (st_r.cms.req[1:0] == CGC_LOOP_BYPASSED_EXTERNAL) &&
                       !stat_s.ext_ref_ok;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.cms = sfield_step(st_r.cms, !bypass_wait);
    st_nxt.mff = sfield_step(st_r.mff, 1'b1);
    st_nxt.odf = sfield_step(st_r.odf, 1'b1);
    if (wr && ofs == CGC_CTRL_ONE_OFS) begin
      // gain, band and reference source are fixed by the first write alone
      if (!st_r.once_done) begin
        st_nxt.once_done = 1'b1;
        st_nxt.hgs       = pwdata[CGC_HGS_BIT];
        st_nxt.fbs       = pwdata[CGC_FBS_BIT];
        st_nxt.ers       = pwdata[CGC_ERS_BIT];
      end
      st_nxt.oko  = pwdata[CGC_OKO_BIT];
      st_nxt.cldo = pwdata[CGC_CLDO_BIT];
      if (!st_r.first_cms) begin
        st_nxt.first_cms   = 1'b1;
        st_nxt.ext_lockout = !cms_w[1];
        st_nxt.pin_claim   = cms_w[1];
        st_nxt.cms         = sfield_write(st_r.cms, {1'b0, cms_w});
      end else if (!(st_r.ext_lockout && cms_w[1])) begin
        st_nxt.cms = sfield_write(st_r.cms, {1'b0, cms_w});
      end
    end
    if (wr && ofs == CGC_CTRL_TWO_OFS) begin
      st_nxt.llre = pwdata[CGC_LLRE_BIT];
      st_nxt.clre = pwdata[CGC_CLRE_BIT];
      st_nxt.mff  = sfield_write(st_r.mff, pwdata[CGC_MFF_LSB +: 3]);
      st_nxt.odf  = sfield_write(st_r.odf, pwdata[CGC_ODF_LSB +: 3]);
    end
    // read data is latched in the setup phase so the access phase needs no wait
    if (setup) begin
      st_nxt.rdata = '0;
      case (ofs)
        CGC_CTRL_ONE_OFS: begin
          st_nxt.rdata[7:0] = {st_r.hgs, st_r.fbs, st_r.ers, st_r.cms.req[1:0],
                               st_r.oko, st_r.cldo, 1'b0};
        end
        CGC_CTRL_TWO_OFS: begin
          st_nxt.rdata[7:0] = {st_r.llre, st_r.mff.req, st_r.clre, st_r.odf.req};
        end
        CGC_STATUS_OFS: begin
          st_nxt.rdata[7:0] = {st_r.cms.act[1:0], stat_s.ref_kind, stat_s.lock_loss,
                               st_r.cms.pend | st_r.mff.pend | st_r.odf.pend,
                               stat_s.clock_loss, stat_s.ext_ref_ok, st_r.pin_claim};
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= '0;
      st_r.hgs  <= CGC_CTRL_ONE_RST[CGC_HGS_BIT];
      st_r.fbs  <= CGC_CTRL_ONE_RST[CGC_FBS_BIT];
      st_r.ers  <= CGC_CTRL_ONE_RST[CGC_ERS_BIT];
      st_r.oko  <= CGC_CTRL_ONE_RST[CGC_OKO_BIT];
      st_r.cldo <= CGC_CTRL_ONE_RST[CGC_CLDO_BIT];
      st_r.llre <= CGC_CTRL_TWO_RST[CGC_LLRE_BIT];
      st_r.clre <= CGC_CTRL_TWO_RST[CGC_CLRE_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

  // unmapped offsets still answer at once, only flagged as an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = st_r.rdata;

  logic ext_mode;
  logic osc_keep_eff;
  logic osc_run;
  logic osc_off;
  assign ext_mode     = st_r.cms.act[1];
  // the keep bit loses its meaning when gain and band are both high
  assign osc_keep_eff = st_r.oko && !(st_r.hgs && st_r.fbs);
  // a crystal only runs for an external mode once the pin was claimed
  assign osc_run      = st_r.pin_claim && st_r.ers && ext_mode;
  // off mode never touches the requested mode, only the oscillator enable
  assign osc_off      = osc_keep_eff ?
                        (st_r.cms.req[1] && stat_s.ref_kind) :
                        (osc_off_enable && st_r.cms.req[1:0] == CGC_LOOP_BYPASSED_EXTERNAL &&
                         stat_s.ref_kind);

  always_comb begin
    cfg                 = '0;
    cfg.high_gain       = st_r.hgs;
    cfg.range_high      = st_r.fbs && ext_mode;
    cfg.ext_ref_crystal = st_r.ers;
    cfg.pin_claim       = st_r.pin_claim;
    cfg.osc_enable      = off_mode ? osc_off : osc_run;
    cfg.loss_detect_en  = !st_r.cldo;
    cfg.mode            = cgc_mode_e'(st_r.cms.act[1:0]);
    cfg.prescale_p      = (st_r.fbs && ext_mode) ? CGC_P_HIGH : CGC_P_LOW;
    cfg.mult_n          = CGC_N_BASE + {1'b0, st_r.mff.act, 1'b0};
    cfg.div_r           = 8'h01 << st_r.odf.act;
  end

  assign lock_loss_irq  = stat_s.lock_loss && !st_r.llre;
  assign lock_loss_rst  = stat_s.lock_loss && st_r.llre;
  assign clock_loss_irq = stat_s.clock_loss && !st_r.cldo && !st_r.clre;
  assign clock_loss_rst = stat_s.clock_loss && !st_r.cldo && st_r.clre;

  logic wr_one;
  logic wr_two;
  assign wr_one = wr && ofs == CGC_CTRL_ONE_OFS;
  assign wr_two = wr && ofs == CGC_CTRL_TWO_OFS;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  once_bits_a: assert property (wr_one && st_r.once_done |=>
    $stable({st_r.hgs, st_r.fbs, st_r.ers}))
    else $error("write-once bit changed after first write");
  gain_out_a: assert property ((cfg.high_gain == st_r.hgs) and
    (wr_one && !st_r.once_done |=> cfg.high_gain == $past(pwdata[CGC_HGS_BIT])))
    else $error("high gain output wrong");
  band_pre_a: assert property (ext_mode |->
    cfg.prescale_p == (st_r.fbs ? 8'h01 : 8'h40))
    else $error("prescale factor wrong");
  band_ignore_a: assert property (!ext_mode |->
    (cfg.prescale_p == 8'h40 && !cfg.range_high))
    else $error("band select acted in internal mode");
  bypass_wait_a: assert property (
    cfg.mode == CGC_LOOP_BYPASSED_EXTERNAL && $changed(cfg.mode) |-> $past(stat_s.ext_ref_ok))
    else $error("bypass mode entered without good reference");
  mode_sync_a: assert property (wr_one && !st_r.cms.pend &&
    !(st_r.ext_lockout && pwdata[CGC_CMS_LSB+1]) && st_r.first_cms && pwdata[4:3] != 2'b10
    |=> ##3 st_r.cms.pend ##1 !st_r.cms.pend)
    else $error("mode field did not settle in time");
  mult_discard_a: assert property (wr_two && st_r.mff.pend |=> $stable(st_r.mff.req))
    else $error("multiplier write taken while busy");
  lockout_a: assert property (st_r.ext_lockout |-> !st_r.cms.req[1] && !st_r.pin_claim)
    else $error("external mode after internal first write");
  osc_off_a: assert property (off_mode && (st_r.hgs && st_r.fbs) |->
    cfg.osc_enable == (osc_off_enable && st_r.cms.req[1:0] == 2'b10 && stat_s.ref_kind))
    else $error("keep bit acted while gain and band high");
  loss_req_a: assert property (stat_s.clock_loss && !st_r.cldo |->
    (clock_loss_rst == st_r.clre) && (clock_loss_irq != st_r.clre))
    else $error("clock loss request wrong");
  lol_req_a: assert property (lock_loss_irq || lock_loss_rst |-> stat_s.lock_loss)
    else $error("lock loss request without loss");
  lol_kind_a: assert property (stat_s.lock_loss |->
    lock_loss_rst == st_r.llre && lock_loss_irq != st_r.llre)
    else $error("lock loss request of wrong kind");
  loss_off_a: assert property (st_r.cldo |->
    !clock_loss_irq && !clock_loss_rst)
    else $error("clock loss request while detection off");
  reset_mode_a: assert property (!$past(presetn) |->
    cfg.mode == CGC_SELF_CLOCKED_MODE && !st_r.once_done)
    else $error("not self-clocked after reset");
  pin_keep_a: assert property (st_r.first_cms |=>
    $stable(st_r.pin_claim))
    else $error("pin claim changed after first mode write");
  mode_keep_a: assert property (off_mode && !wr_one |=>
    $stable(st_r.cms.req))
    else $error("requested mode changed in off mode");
  div_mult_a: assert property ($changed(st_r.odf.act) |->
    cfg.div_r == (8'h01 << st_r.odf.act) && cfg.mult_n == 5'(4 + 2 * st_r.mff.act))
    else $error("divider or multiplier wrong");


  // main scenarios
  ext_mode_c:  cover property (cfg.mode == CGC_LOOP_ENGAGED_EXTERNAL);
  osc_keep_c:  cover property (off_mode && st_r.oko && st_r.hgs && st_r.fbs);
  bypass_c:    cover property (bypass_wait [*4] ##1 cfg.mode == CGC_LOOP_BYPASSED_EXTERNAL);
  discard_c:   cover property (wr_two && st_r.mff.pend);
  lockout_c:   cover property (st_r.ext_lockout && wr_one && pwdata[CGC_CMS_LSB+1]);
endmodule

// ### tb/cgc_src_model.sv
// behavioural external reference source facing the clock generator control
`timescale 1ns/1ps
module cgc_src_model
  import cgc_pkg::*;
#(
  parameter int STARTUP = 20
) (
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire cgc_cfg_s cfg,
  input  wire logic     lose_clk,
  input  wire logic     lose_lock,
  output cgc_stat_s     stat
);
  int run_r;
  // the reference only settles once the pin is claimed and has had time to start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 0;
    end else if (lose_clk) begin
      run_r <= 0;
    end else if (cfg.pin_claim && run_r < STARTUP) begin
      run_r <= run_r + 1;
    end
  end
  assign stat.ext_ref_ok = (run_r >= STARTUP);
  assign stat.ref_kind   = cfg.ext_ref_crystal;
  assign stat.clock_loss = lose_clk;
  assign stat.lock_loss  = lose_lock;
endmodule

// ### tb/tb_clock_generator_control.sv
// self-checking bench for the clock generator control registers
`timescale 1ns/1ps
module tb_clock_generator_control;
  import cgc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        off_mode, osc_off_enable, lose_clk, lose_lock;
  logic        ll_irq, ll_rst, cl_irq, cl_rst;
  cgc_stat_s   stat;
  cgc_cfg_s    cfg;
  int          n_errors, n_tests;

  cgc_ctrl #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stat_in(stat), .off_mode(off_mode),
    .osc_off_enable(osc_off_enable), .cfg(cfg), .lock_loss_irq(ll_irq),
    .lock_loss_rst(ll_rst), .clock_loss_irq(cl_irq), .clock_loss_rst(cl_rst));
  cgc_src_model #(.STARTUP(20)) src (.pclk(pclk), .presetn(presetn), .cfg(cfg),
    .lose_clk(lose_clk), .lose_lock(lose_lock), .stat(stat));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task idle(input int n);
    psel <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  // called just after a rising edge; psel stays up so transfers can run back to back
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
  endtask

  task rst_dut;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task t_reset;
    apb(1'b0, CGC_CTRL_ONE_OFS, 8'h00);
    chk(rd, 32'(CGC_CTRL_ONE_RST));
    apb(1'b0, CGC_CTRL_TWO_OFS, 8'h00);
    chk(rd, 32'(CGC_CTRL_TWO_RST));
    apb(1'b0, 12'h00C, 8'h00);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    idle(1);
    chk(32'(cfg.mode), 32'h0);
    chk(32'({cfg.prescale_p, 3'h0, cfg.mult_n, cfg.div_r}), 32'h0040_0401);
  endtask

  task t_ext;
    apb(1'b1, CGC_CTRL_ONE_OFS, 8'hB8);
    apb(1'b1, CGC_CTRL_ONE_OFS, 8'h40);
    apb(1'b0, CGC_CTRL_ONE_OFS, 8'h00);
    chk(32'(rd[7:5]), 32'h5);
    idle(6);
    chk(32'(cfg.mode), 32'h3);
    chk(32'({cfg.high_gain, cfg.pin_claim, cfg.ext_ref_crystal}), 32'h7);
    chk(32'({cfg.prescale_p, 7'h0, cfg.range_high}), 32'h4000);
    off_mode       <= 1'b1;
    osc_off_enable <= 1'b0;
    idle(3);
    chk(32'(cfg.mode), 32'h3);
    chk(32'(cfg.osc_enable), 32'h0);
    apb(1'b1, CGC_CTRL_ONE_OFS, 8'hBC);
    idle(6);
    chk(32'(cfg.osc_enable), 32'h1);
    off_mode <= 1'b0;
  endtask

  task t_mult;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, CGC_CTRL_TWO_OFS, {1'b0, 3'(c), 1'b0, 3'(c)});
      apb(1'b1, CGC_CTRL_TWO_OFS, 8'h00);
      idle(6);
      chk(32'(cfg.mult_n), 32'(4 + 2 * c));
      chk(32'(cfg.div_r), 32'(1 << c));
    end
  endtask

  task t_loss;
    apb(1'b1, CGC_CTRL_TWO_OFS, 8'h00);
    idle(6);
    lose_lock <= 1'b1;
    lose_clk  <= 1'b1;
    idle(4);
    chk(32'({ll_irq, ll_rst, cl_irq, cl_rst}), 32'hA);
    apb(1'b1, CGC_CTRL_TWO_OFS, 8'h88);
    idle(2);
    chk(32'({ll_irq, ll_rst, cl_irq, cl_rst}), 32'h5);
    apb(1'b1, CGC_CTRL_ONE_OFS, 8'hBE);
    idle(2);
    chk(32'({ll_irq, ll_rst, cl_irq, cl_rst, cfg.loss_detect_en}), 32'h8);
    lose_lock <= 1'b0;
    lose_clk  <= 1'b0;
  endtask

  task t_lockout;
    rst_dut();
    apb(1'b1, CGC_CTRL_ONE_OFS, 8'h48);
    idle(6);
    apb(1'b1, CGC_CTRL_ONE_OFS, 8'h18);
    idle(6);
    chk(32'(cfg.mode), 32'h1);
    chk(32'(cfg.pin_claim), 32'h0);
    chk(32'({cfg.prescale_p, 7'h0, cfg.range_high}), 32'h4000);
    chk(32'(cfg.ext_ref_crystal), 32'h0);
  endtask

  // gain and band both high: the keep bit must not hold the oscillator on
  task t_bypass;
    rst_dut();
    apb(1'b1, CGC_CTRL_ONE_OFS, 8'hF4);
    idle(8);
    chk(32'(cfg.mode), 32'h0);
    apb(1'b0, CGC_STATUS_OFS, 8'h00);
    chk(rd, 32'h29);
    idle(30);
    chk(32'(cfg.mode), 32'h2);
    chk(32'({cfg.prescale_p, 7'h0, cfg.range_high}), 32'h0101);
    chk(32'(cfg.ext_ref_crystal), 32'h1);
    apb(1'b0, CGC_STATUS_OFS, 8'h00);
    chk(rd, 32'hA3);
    off_mode       <= 1'b1;
    osc_off_enable <= 1'b0;
    idle(2);
    chk(32'(cfg.osc_enable), 32'h0);
    osc_off_enable <= 1'b1;
    idle(1);
    chk(32'(cfg.osc_enable), 32'h1);
    off_mode <= 1'b0;
  endtask

  task end_sim;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    n_errors       = 0;
    n_tests        = 0;
    presetn        = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 12'h000;
    pwdata         = 32'h0;
    off_mode       = 1'b0;
    osc_off_enable = 1'b0;
    lose_clk       = 1'b0;
    lose_lock      = 1'b0;
    @(posedge pclk);
    rst_dut();
    t_reset();
    t_ext();
    t_mult();
    t_loss();
    t_lockout();
    t_bypass();
    end_sim();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule
